// ==== dpbr_out_stage.sv ====
// Read data latch with optional pipeline register
`timescale 1ns/1ps
`default_nettype none
module dpbr_out_stage #(
  parameter int WIDTH = dpbr_pkg::OUT_W
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             pipe_i,
  output logic      [WIDTH-1:0] data_o
);
  import dpbr_pkg::*;

  logic [WIDTH-1:0] latch_reg;
  logic [WIDTH-1:0] pipe_reg;

  if (WIDTH != OUT_W) begin : g_chk
    $error("dpbr_out_stage: WIDTH must equal OUT_W");
  end

  // Latch holds until the next cycle with load_i high
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_reg <= DOUT_RST;
    end else if (load_i) begin
      latch_reg <= data_i;
    end
  end

  // Extra stage adds one cycle of latency
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe_reg <= DOUT_RST;
    end else begin
      pipe_reg <= latch_reg;
    end
  end

  assign data_o = pipe_i ? pipe_reg : latch_reg;
endmodule
`default_nettype wire

// ==== dpbr_pkg.sv ====
// Shared constants and types for the dual-port block memory
package dpbr_pkg;
  localparam int DATA_BITS   = 16384;
  localparam int PAR_BITS    = 2048;
  localparam int ADDR_W      = 14;
  localparam int PADDR_W     = 11;
  localparam int DW          = 32;
  localparam int PW          = 4;
  localparam int WSEL_W      = 3;
  localparam int WMODE_W     = 2;
  localparam int FULL_LOG    = 14;
  localparam int HALF_LOG    = 13;
  localparam int OUT_W       = DW + PW;
  localparam logic [OUT_W-1:0] DOUT_RST = 36'h0_0000_0000;

  typedef enum logic [WSEL_W-1:0] {
    DPBR_W1,
    DPBR_W2,
    DPBR_W4,
    DPBR_W9,
    DPBR_W18,
    DPBR_W36
  } dpbr_width_e;

  typedef enum logic [WMODE_W-1:0] {
    DPBR_READ_FIRST,
    DPBR_WRITE_FIRST,
    DPBR_NO_CHANGE
  } dpbr_wmode_e;
endpackage

// ==== dpbr_ram.sv ====
// Dual-port 18 Kb block memory with per-port shape and write mode
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The memory holds 18 Kb and its two ports share the array, one clock and one reset.
// - Each port acts on the clock edge, capturing its inputs there except the pipeline select, which acts at once.
// - Read data sits in a latch that holds until the port's next read, or next write outside no-change mode; port A's latch holds throughout sdp_mode.
// - An optional pipeline register per port delays read data one cycle.
// - A write shows old data, new data, or holds output, per port mode; a port A write under sdp_mode always holds output.
// - Each port is 16Kx1, 8Kx2, 4Kx4, 2Kx9/8, 1Kx18/16 or 512x36/32.
// - In x9, x18 and x36 shapes the extra bits are stored as parity.
// - The ports may use different shapes over the same bit array.
// - The array may act as two 9 Kb halves, each from 8Kx1 to 512x18.
// - A half offers 256x36 only with port A writing and port B reading.
module dpbr_ram (
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic                              split_i,
  input  wire logic                              sdp_i,
  input  wire logic                              a_en_i,
  input  wire logic                              a_we_i,
  input  wire logic [dpbr_pkg::ADDR_W-1:0]       a_addr_i,
  input  wire logic [dpbr_pkg::DW-1:0]           a_din_i,
  input  wire logic [dpbr_pkg::PW-1:0]           a_dinp_i,
  input  wire logic [dpbr_pkg::WSEL_W-1:0]       a_width_i,
  input  wire logic [dpbr_pkg::WMODE_W-1:0]      a_wmode_i,
  input  wire logic                              a_pipe_i,
  output logic      [dpbr_pkg::DW-1:0]           a_dout_o,
  output logic      [dpbr_pkg::PW-1:0]           a_doutp_o,
  input  wire logic                              b_en_i,
  input  wire logic                              b_we_i,
  input  wire logic [dpbr_pkg::ADDR_W-1:0]       b_addr_i,
  input  wire logic [dpbr_pkg::DW-1:0]           b_din_i,
  input  wire logic [dpbr_pkg::PW-1:0]           b_dinp_i,
  input  wire logic [dpbr_pkg::WSEL_W-1:0]       b_width_i,
  input  wire logic [dpbr_pkg::WMODE_W-1:0]      b_wmode_i,
  input  wire logic                              b_pipe_i,
  output logic      [dpbr_pkg::DW-1:0]           b_dout_o,
  output logic      [dpbr_pkg::PW-1:0]           b_doutp_o
);
  import dpbr_pkg::*;

  // Shared storage: data bits and parity bits
  logic data_mem [DATA_BITS];
  logic par_mem  [PAR_BITS];

  // Per-port views of the separate ports
  logic                en_p    [2];
  logic                we_p    [2];
  logic [ADDR_W-1:0]   addr_p  [2];
  logic [DW-1:0]       din_p   [2];
  logic [PW-1:0]       dinp_p  [2];
  logic [WSEL_W-1:0]   width_p [2];
  logic [WMODE_W-1:0]  wmode_p [2];
  logic                pipe_p  [2];
  logic [OUT_W-1:0]    dout_p  [2];

  // Decoded access per port
  logic [DW-1:0]       dmask   [2];
  logic [PW-1:0]       pmask   [2];
  logic [ADDR_W-1:0]   dbase   [2];
  logic [PADDR_W-1:0]  pbase   [2];
  logic                wr_go   [2];
  logic                rd_go   [2];
  logic [OUT_W-1:0]    rd_word [2];
  logic [OUT_W-1:0]    ld_word [2];
  logic                ld_go   [2];

  logic                sdp_mode;

  assign sdp_mode = split_i & sdp_i;

  assign en_p[0]    = a_en_i;
  assign we_p[0]    = a_we_i;
  assign addr_p[0]  = a_addr_i;
  assign din_p[0]   = a_din_i;
  assign dinp_p[0]  = a_dinp_i;
  assign width_p[0] = a_width_i;
  assign wmode_p[0] = a_wmode_i;
  assign pipe_p[0]  = a_pipe_i;
  assign en_p[1]    = b_en_i;
  assign we_p[1]    = b_we_i;
  assign addr_p[1]  = b_addr_i;
  assign din_p[1]   = b_din_i;
  assign dinp_p[1]  = b_dinp_i;
  assign width_p[1] = b_width_i;
  assign wmode_p[1] = b_wmode_i;
  assign pipe_p[1]  = b_pipe_i;

  assign a_dout_o  = dout_p[0][DW-1:0];
  assign a_doutp_o = dout_p[0][OUT_W-1:DW];
  assign b_dout_o  = dout_p[1][DW-1:0];
  assign b_doutp_o = dout_p[1][OUT_W-1:DW];

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [2:0]          dshift;
    logic [1:0]          pshift;
    logic [4:0]          alog;
    logic [ADDR_W-1:0]   amask;
    logic [ADDR_W-1:0]   idx;
    logic                half;
    logic                legal;
    logic                w36;
    logic [OUT_W-1:0]    wr_word;

    // Shape decode: data lanes, parity lanes and address scaling
    always_comb begin
      dshift = 3'h0;
      pshift = 2'h0;
      dmask[p] = 32'h0000_0001;
      pmask[p] = 4'h0;
      w36 = 1'b0;
      case (dpbr_width_e'(width_p[p]))
        DPBR_W1: begin
          dshift = 3'h0;
        end
        DPBR_W2: begin
          dshift = 3'h1;
          dmask[p] = 32'h0000_0003;
        end
        DPBR_W4: begin
          dshift = 3'h2;
          dmask[p] = 32'h0000_000f;
        end
        DPBR_W9: begin
          dshift = 3'h3;
          dmask[p] = 32'h0000_00ff;
          pmask[p] = 4'h1;
        end
        DPBR_W18: begin
          dshift = 3'h4;
          pshift = 2'h1;
          dmask[p] = 32'h0000_ffff;
          pmask[p] = 4'h3;
        end
        DPBR_W36: begin
          dshift = 3'h5;
          pshift = 2'h2;
          dmask[p] = 32'hffff_ffff;
          pmask[p] = 4'hf;
          w36 = 1'b1;
        end
        default: begin
          dshift = 3'h0;
        end
      endcase
    end

    // Address mapping onto the common bit array
    always_comb begin
      alog  = split_i ? 5'(HALF_LOG) : 5'(FULL_LOG);
      alog  = alog - {2'h0, dshift};
      amask = ADDR_W'((15'h0001 << alog) - 15'h0001);
      idx   = addr_p[p] & amask;
      half  = split_i & ~sdp_i & (p == 1);
      dbase[p] = (idx << dshift) | {half, 13'h0000};
      pbase[p] = PADDR_W'(idx << pshift) | {half, 10'h000};
    end

    // Access qualification per port
    always_comb begin
      legal    = ~(split_i & w36) | sdp_i;
      wr_go[p] = en_p[p] & we_p[p] & legal & ~(sdp_mode & (p == 1));
      // Refused write on the read-only port must not reload the latch
      rd_go[p] = en_p[p] & legal & ~(sdp_mode & (p == 0))
               & ~(sdp_mode & (p == 1) & we_p[p]);
    end

    // Old contents at the addressed word, before this edge's write
    always_comb begin
      rd_word[p] = '0;
      for (int i = 0; i < DW; i++) begin
        if (dmask[p][i]) begin
          rd_word[p][i] = data_mem[dbase[p] + ADDR_W'(i)];
        end
      end
      for (int j = 0; j < PW; j++) begin
        if (pmask[p][j]) begin
          rd_word[p][DW+j] = par_mem[pbase[p] + PADDR_W'(j)];
        end
      end
    end

    // Write-mode choice for the output latch
    always_comb begin
      wr_word  = {dinp_p[p] & pmask[p], din_p[p] & dmask[p]};
      ld_go[p] = rd_go[p];
      ld_word[p] = rd_word[p];
      if (wr_go[p]) begin
        case (dpbr_wmode_e'(wmode_p[p]))
          DPBR_READ_FIRST: begin
            ld_word[p] = rd_word[p];
          end
          DPBR_WRITE_FIRST: begin
            ld_word[p] = wr_word;
          end
          DPBR_NO_CHANGE: begin
            ld_go[p] = 1'b0;
          end
          default: begin
            ld_word[p] = rd_word[p];
          end
        endcase
      end
    end

    dpbr_out_stage #(
      .WIDTH (OUT_W)
    ) u_out (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .load_i    (ld_go[p]),
      .data_i    (ld_word[p]),
      .pipe_i    (pipe_p[p]),
      .data_o    (dout_p[p])
    );
  end

  // Array writes on the edge; port B wins a same-bit collision
  always_ff @(posedge sys_clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (wr_go[p]) begin
        for (int i = 0; i < DW; i++) begin
          if (dmask[p][i]) begin
            data_mem[dbase[p] + ADDR_W'(i)] <= din_p[p][i];
          end
        end
        for (int j = 0; j < PW; j++) begin
          if (pmask[p][j]) begin
            par_mem[pbase[p] + PADDR_W'(j)] <= dinp_p[p][j];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== dpbr_ram_monitor.sv ====
// Port checks for the dual-port block memory
`timescale 1ns/1ps
`default_nettype none
module dpbr_ram_monitor
  import dpbr_pkg::*;
(
  input wire logic               sys_clk_i,
  input wire logic               rst_n_i,
  input wire logic               split_i,
  input wire logic               sdp_i,
  input wire logic               a_en_i,
  input wire logic               a_we_i,
  input wire logic [DW-1:0]      a_din_i,
  input wire logic [WSEL_W-1:0]  a_width_i,
  input wire logic [WMODE_W-1:0] a_wmode_i,
  input wire logic               a_pipe_i,
  input wire logic [DW-1:0]      a_dout_o,
  input wire logic               b_en_i,
  input wire logic               b_we_i,
  input wire logic [DW-1:0]      b_din_i,
  input wire logic [PW-1:0]      b_dinp_i,
  input wire logic [WSEL_W-1:0]  b_width_i,
  input wire logic [WMODE_W-1:0] b_wmode_i,
  input wire logic               b_pipe_i,
  input wire logic [DW-1:0]      b_dout_o,
  input wire logic [PW-1:0]      b_doutp_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_a_idle;
    !a_pipe_i ##1 !a_en_i && !a_pipe_i ##1 !a_pipe_i |-> $stable(a_dout_o);
  endproperty
  a_a_idle: assert property (p_a_idle) else $error("a idle moved");
  property p_b_idle;
    !b_pipe_i ##1 !b_en_i && !b_pipe_i ##1 !b_pipe_i |-> $stable(b_dout_o);
  endproperty
  a_b_idle: assert property (p_b_idle) else $error("b idle moved");
  property p_a_pidle;
    a_pipe_i && !a_en_i ##1 a_pipe_i && !a_en_i ##1 a_pipe_i
      |-> $stable(a_dout_o);
  endproperty
  a_a_pidle: assert property (p_a_pidle) else $error("a pipe moved");
  property p_a_nochg;
    !a_pipe_i ##1 a_en_i && a_we_i && a_wmode_i == DPBR_NO_CHANGE
      && !a_pipe_i ##1 !a_pipe_i |-> $stable(a_dout_o);
  endproperty
  a_a_nochg: assert property (p_a_nochg) else $error("a nochg");
  property p_a_wfirst;
    a_en_i && a_we_i && a_wmode_i == DPBR_WRITE_FIRST && !a_pipe_i
      && a_width_i == DPBR_W36 && !split_i |=> a_dout_o == $past(a_din_i);
  endproperty
  a_a_wfirst: assert property (p_a_wfirst) else $error("a wfirst");
  property p_a_wpipe;
    a_en_i && a_we_i && a_wmode_i == DPBR_WRITE_FIRST && a_pipe_i
      && a_width_i == DPBR_W36 && !split_i ##1 a_pipe_i
      |=> a_dout_o == $past(a_din_i, 2);
  endproperty
  a_a_wpipe: assert property (p_a_wpipe) else $error("a wpipe");
  property p_b_x9;
    b_en_i && b_we_i && b_wmode_i == DPBR_WRITE_FIRST && !b_pipe_i
      && b_width_i == DPBR_W9 && !split_i |=> {b_doutp_o, b_dout_o} ==
      {3'h0, $past(b_dinp_i[0]), 24'h0, $past(b_din_i[7:0])};
  endproperty
  a_b_x9: assert property (p_b_x9) else $error("b x9");
  property p_b_sdp;
    !b_pipe_i ##1 split_i && sdp_i && b_en_i && b_we_i && !b_pipe_i
      ##1 !b_pipe_i |-> $stable(b_dout_o);
  endproperty
  a_b_sdp: assert property (p_b_sdp) else $error("b sdp");
  c_pipe: cover property (a_en_i && a_we_i && a_pipe_i);
  c_sdp: cover property (split_i && sdp_i && b_en_i);
  c_read: cover property (b_en_i && !b_we_i);
endmodule
`default_nettype wire

// ==== dpbr_user_port.sv ====
// User-logic model driving one memory port
`timescale 1ns/1ps
`default_nettype none
module dpbr_user_port
  import dpbr_pkg::*;
(
  input  wire logic              clk_i,
  output var  logic              en_o,
  output var  logic              we_o,
  output var  logic [ADDR_W-1:0] addr_o,
  output var  logic [DW-1:0]     din_o,
  output var  logic [PW-1:0]     dinp_o
);
  initial begin
    {en_o, we_o, addr_o, din_o, dinp_o} = '0;
  end
  // One access across one edge; callers keep the ports apart
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DW-1:0] d, input logic [PW-1:0] p);
    @(negedge clk_i);
    {en_o, we_o, addr_o, din_o, dinp_o} = {1'h1, w, a, d, p};
    @(negedge clk_i);
    {en_o, we_o, addr_o, din_o, dinp_o} = {2'h0, ~a, ~d, ~p};
  endtask
endmodule
`default_nettype wire

// ==== tb_dual_port_block_ram.sv ====
// Self-checking bench for the dual-port block memory
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dual_port_block_ram;
  import dpbr_pkg::*;
  logic sys_clk_i = 0, rst_n_i = 0, split_i = 0, sdp_i = 0;
  logic a_pipe_i = 0, b_pipe_i = 0;
  logic [WSEL_W-1:0] a_width_i = 3'h5, b_width_i = 3'h0;
  logic [WMODE_W-1:0] a_wmode_i = 2'h1, b_wmode_i = 2'h1;
  wire a_en_i, a_we_i, b_en_i, b_we_i;
  wire [ADDR_W-1:0] a_addr_i, b_addr_i;
  wire [DW-1:0] a_din_i, b_din_i, a_dout_o, b_dout_o;
  wire [PW-1:0] a_dinp_i, b_dinp_i, a_doutp_o, b_doutp_o;
  int fail_count = 0, compares = 0, cycles = 0;
  dpbr_ram dut (.*);
  dpbr_user_port pa (.clk_i(sys_clk_i), .en_o(a_en_i), .we_o(a_we_i),
    .addr_o(a_addr_i), .din_o(a_din_i), .dinp_o(a_dinp_i));
  dpbr_user_port pb (.clk_i(sys_clk_i), .en_o(b_en_i), .we_o(b_we_i),
    .addr_o(b_addr_i), .din_o(b_din_i), .dinp_o(b_dinp_i));
  always #20 sys_clk_i = ~sys_clk_i;
  task automatic final_report();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic t_wide();
    pa.acc(1'h1, 14'h010, 32'hdead_beef, 4'ha);
    `CHK({a_doutp_o, a_dout_o}, 36'ha_dead_beef)
    pb.acc(1'h0, 14'h0204, 32'h0, 4'h0);
    `CHK(b_dout_o, 32'h0)
    pb.acc(1'h0, 14'h0205, 32'h0, 4'h0);
    `CHK(b_dout_o, 32'h1)
    repeat (3) @(negedge sys_clk_i);
    `CHK(b_dout_o, 32'h1)
  endtask
  task automatic t_modes();
    a_wmode_i = 2'h0;
    pa.acc(1'h1, 14'h010, 32'h1234_5678, 4'h0);
    `CHK(a_dout_o, 32'hdead_beef)
    a_wmode_i = 2'h2;
    pa.acc(1'h1, 14'h010, 32'h0bad_f00d, 4'h0);
    `CHK(a_dout_o, 32'hdead_beef)
    pa.acc(1'h0, 14'h010, 32'h0, 4'h0);
    `CHK(a_dout_o, 32'h0bad_f00d)
  endtask
  task automatic t_pipe();
    a_wmode_i = 2'h1;
    a_pipe_i = 1'h1;
    repeat (3) @(negedge sys_clk_i);
    pa.acc(1'h1, 14'h020, 32'h5a5a_a5a5, 4'h0);
    `CHK(a_dout_o, 32'h0bad_f00d)
    @(negedge sys_clk_i);
    `CHK(a_dout_o, 32'h5a5a_a5a5)
    a_pipe_i = 1'h0;
  endtask
  task automatic t_b9();
    b_width_i = 3'h3;
    pb.acc(1'h1, 14'h07ff, 32'h1ab, 4'hf);
    `CHK({b_doutp_o, b_dout_o}, 36'h1_0000_00ab)
  endtask
  task automatic t_split();
    split_i = 1'h1;
    a_width_i = 3'h4;
    b_width_i = 3'h4;
    fork
      pa.acc(1'h1, 14'h0, 32'h1111, 4'h0);
      pb.acc(1'h1, 14'h0, 32'h2222, 4'h0);
    join
    pa.acc(1'h0, 14'h0, 32'h0, 4'h0);
    `CHK(a_dout_o, 32'h1111)
    sdp_i = 1'h1;
    pb.acc(1'h1, 14'h0, 32'h3333, 4'h0);
    `CHK(b_dout_o, 32'h2222)
    pb.acc(1'h0, 14'h0, 32'h0, 4'h0);
    `CHK(b_dout_o, 32'h1111)
  endtask
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1'h1;
    t_wide();
    t_modes();
    t_pipe();
    t_b9();
    t_split();
    final_report();
  end
endmodule
bind dpbr_ram dpbr_ram_monitor mon (.*);
`undef CHK
`default_nettype wire
